// ===== src/drt_defines.svh
// constants of the dual mode reload timer
`ifndef DRT_DEFINES_SVH
`define DRT_DEFINES_SVH

// special-function register addresses
`define DRT_ADDR_CTRL     8'h91
`define DRT_ADDR_RL_LO    8'h92
`define DRT_ADDR_RL_HI    8'h93
`define DRT_ADDR_CNT_LO   8'h94
`define DRT_ADDR_CNT_HI   8'h95

// control register fields
`define DRT_BIT_HIGH_OVF  7
`define DRT_BIT_LOW_OVF   6
`define DRT_BIT_LOW_IEN   5
`define DRT_BIT_CAP_EN    4
`define DRT_BIT_SPLIT     3
`define DRT_BIT_RUN       2
`define DRT_BIT_XCLK      0

// reset values and limits
`define DRT_RESET_BYTE    8'h00
`define DRT_BYTE_FULL     8'hff

// clock dividers, in system clock cycles and external edges
`define DRT_SYS_DIV       4'hc
`define DRT_EXT_DIV       3'h7

`endif

// ===== src/drt_pkg.sv
// types of the dual mode reload timer
package drt_pkg;
    typedef logic [7:0] drt_byte_t;
    typedef enum logic {
        DRT_MODE_WIDE,
        DRT_MODE_SPLIT
    } drt_mode_t;
endpackage : drt_pkg

// ===== src/drt_tick_if.sv
// tick enables passed from the tick generator to the timer core
interface drt_tick_if;
    logic div12_tick;
    logic ext_tick;
    logic lfo_rise;
    modport gen (output div12_tick, output ext_tick, output lfo_rise);
    modport use_side (input div12_tick, input ext_tick, input lfo_rise);
endinterface : drt_tick_if

// ===== src/drt_tick_gen.sv
// tick generator: div-12 enable, synced ext div-8, lfo edge
module drt_tick_gen
    import drt_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ext_osc,
    input  wire logic i_lfo,
    drt_tick_if.gen   tk
);
    `include "drt_defines.svh"

    logic [3:0] div_reg;
    logic       ext_s1_reg;
    logic       ext_s2_reg;
    logic       ext_d_reg;
    logic [2:0] ext_cnt_reg;
    logic       lfo_s1_reg;
    logic       lfo_s2_reg;
    logic       lfo_d_reg;

    // ----------------------------------------------------------------
    // system clock divided by 12
    // ----------------------------------------------------------------
    wire logic div_end = (div_reg == (`DRT_SYS_DIV - 4'h1));

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) div_reg <= 4'h0;
        else div_reg <= div_end ? 4'h0 : div_reg + 4'h1;
    end

    // ----------------------------------------------------------------
    // pin synchronisers, first stage read only by the second
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            {ext_s1_reg, ext_s2_reg, ext_d_reg} <= 3'h0;
            {lfo_s1_reg, lfo_s2_reg, lfo_d_reg} <= 3'h0;
        end else begin
            {ext_s1_reg, ext_s2_reg, ext_d_reg} <=
                {i_ext_osc, ext_s1_reg, ext_s2_reg};
            {lfo_s1_reg, lfo_s2_reg, lfo_d_reg} <=
                {i_lfo, lfo_s1_reg, lfo_s2_reg};
        end
    end

    // external oscillator rising edges counted by eight
    wire logic ext_rise = ext_s2_reg && !ext_d_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) ext_cnt_reg <= 3'h0;
        else if (ext_rise) ext_cnt_reg <= ext_cnt_reg + 3'h1;
    end

    assign tk.div12_tick = div_end;
    assign tk.ext_tick   = ext_rise && (ext_cnt_reg == `DRT_EXT_DIV);
    assign tk.lfo_rise   = lfo_s2_reg && !lfo_d_reg;
endmodule : drt_tick_gen

// ===== src/drt_top.sv
// dual mode reload timer: sfr registers, counters, flags, request
module drt_top
    import drt_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RST_N,
    input  wire logic [7:0] I_SFR_ADDR,
    input  wire logic [7:0] I_SFR_WDATA,
    input  wire logic       I_SFR_WR,
    input  wire logic       I_SFR_RD,
    input  wire logic       I_TIMER_IRQ_EN,
    input  wire logic       I_HIGH_BYTE_CLOCK_SELECT,
    input  wire logic       I_LOW_BYTE_CLOCK_SELECT,
    input  wire logic       I_EXT_OSC,
    input  wire logic       I_LFO,
    output logic      [7:0] O_SFR_RDATA,
    output logic            O_IRQ_REQ
);
    `include "drt_defines.svh"

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic      high_overflow_flag_reg;
    logic      low_overflow_flag_reg;
    logic      low_byte_irq_enable_reg;
    logic      lfo_capture_enable_reg;
    drt_mode_t mode_reg;
    logic      run_control_reg;
    logic      external_clock_select_reg;
    drt_byte_t reload_low_byte_reg;
    drt_byte_t reload_high_byte_reg;
    drt_byte_t count_low_byte_reg;
    drt_byte_t count_high_byte_reg;
    drt_byte_t rdata_reg;
    logic      irq_reg;

    // ----------------------------------------------------------------
    // tick sources
    // ----------------------------------------------------------------
    drt_tick_if tk ();

    drt_tick_gen u_tick_gen (
        .i_clk     (I_CLK),
        .i_rst_n   (I_RST_N),
        .i_ext_osc (I_EXT_OSC),
        .i_lfo     (I_LFO),
        .tk        (tk)
    );

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire logic wr_ctrl   = I_SFR_WR && (I_SFR_ADDR == `DRT_ADDR_CTRL);
    wire logic wr_rl_lo  = I_SFR_WR && (I_SFR_ADDR == `DRT_ADDR_RL_LO);
    wire logic wr_rl_hi  = I_SFR_WR && (I_SFR_ADDR == `DRT_ADDR_RL_HI);
    wire logic wr_cnt_lo = I_SFR_WR && (I_SFR_ADDR == `DRT_ADDR_CNT_LO);
    wire logic wr_cnt_hi = I_SFR_WR && (I_SFR_ADDR == `DRT_ADDR_CNT_HI);

    // ----------------------------------------------------------------
    // clock selection per byte
    // ----------------------------------------------------------------
    // shared slow source: one select bit for both bytes
    wire logic src_tick = external_clock_select_reg ?
                          tk.ext_tick : tk.div12_tick;

    // select of one means every system clock cycle
    wire logic tick_low  = I_LOW_BYTE_CLOCK_SELECT || src_tick;
    wire logic tick_high = I_HIGH_BYTE_CLOCK_SELECT || src_tick;

    // ----------------------------------------------------------------
    // advance enables
    // ----------------------------------------------------------------
    wire logic is_split = (mode_reg == DRT_MODE_SPLIT);

    // wide mode: run gates the whole count, low select clocks it
    wire logic adv_wide = !is_split && run_control_reg
                          && tick_low;

    // split mode: low byte always runs, high byte gated by run
    wire logic adv_lo_split = is_split && tick_low;
    wire logic adv_hi_split = is_split && run_control_reg
                              && tick_high;

    wire logic low_full  = (count_low_byte_reg == `DRT_BYTE_FULL);
    wire logic high_full = (count_high_byte_reg == `DRT_BYTE_FULL);

    // ----------------------------------------------------------------
    // rollover events, only when the byte actually advances
    // ----------------------------------------------------------------
    wire logic wrap_wide = adv_wide && low_full && high_full;

    wire logic low_roll = (adv_wide || adv_lo_split)
                          && low_full;

    wire logic high_roll = wrap_wide
                           || (adv_hi_split && high_full);

    wire logic capture = lfo_capture_enable_reg && I_TIMER_IRQ_EN
                         && tk.lfo_rise;

    // ----------------------------------------------------------------
    // next count values
    // ----------------------------------------------------------------
    // low byte: wide wrap and split wrap both reload the low byte
    wire drt_byte_t low_inc = drt_byte_t'(count_low_byte_reg + 8'h01);

    wire drt_byte_t low_adv =
        (wrap_wide || (adv_lo_split && low_full)) ?
        reload_low_byte_reg : low_inc;

    wire drt_byte_t count_low_byte_next =
        wr_cnt_lo                    ? I_SFR_WDATA :
        (adv_wide || adv_lo_split)   ? low_adv :
                                       count_low_byte_reg;

    // high byte: carry from low in wide mode, own ticks in split
    wire drt_byte_t high_inc = drt_byte_t'(count_high_byte_reg + 8'h01);

    wire logic high_step = (adv_wide && low_full) || adv_hi_split;

    wire drt_byte_t high_adv =
        (wrap_wide || (adv_hi_split && high_full)) ?
        reload_high_byte_reg : high_inc;

    wire drt_byte_t count_high_byte_next =
        wr_cnt_hi  ? I_SFR_WDATA :
        high_step  ? high_adv :
                     count_high_byte_reg;

    // ----------------------------------------------------------------
    // next reload values: capture wins over a software write
    // ----------------------------------------------------------------
    wire drt_byte_t reload_low_byte_next =
        capture  ? count_low_byte_reg :
        wr_rl_lo ? I_SFR_WDATA :
                   reload_low_byte_reg;

    wire drt_byte_t reload_high_byte_next =
        capture  ? count_high_byte_reg :
        wr_rl_hi ? I_SFR_WDATA :
                   reload_high_byte_reg;

    // ----------------------------------------------------------------
    // overflow flags: set beats a clear written in the same cycle
    // ----------------------------------------------------------------
    wire logic high_flag_base = wr_ctrl ?
        I_SFR_WDATA[`DRT_BIT_HIGH_OVF] : high_overflow_flag_reg;

    wire logic high_overflow_flag_next =
        high_flag_base || high_roll || capture;

    wire logic low_flag_base = wr_ctrl ?
        I_SFR_WDATA[`DRT_BIT_LOW_OVF] : low_overflow_flag_reg;

    wire logic low_overflow_flag_next =
        low_flag_base || low_roll;

    // ----------------------------------------------------------------
    // interrupt request level
    // ----------------------------------------------------------------
    // low flag only counts when its own enable is set
    wire logic irq_next = I_TIMER_IRQ_EN
        && (high_overflow_flag_reg
            || (low_byte_irq_enable_reg
                && low_overflow_flag_reg));

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire drt_byte_t ctrl_view = {
        high_overflow_flag_reg,
        low_overflow_flag_reg,
        low_byte_irq_enable_reg,
        lfo_capture_enable_reg,
        is_split,
        run_control_reg,
        1'h0,
        external_clock_select_reg
    };

    wire drt_byte_t rd_mux =
        (I_SFR_ADDR == `DRT_ADDR_CTRL)   ? ctrl_view :
        (I_SFR_ADDR == `DRT_ADDR_RL_LO)  ? reload_low_byte_reg :
        (I_SFR_ADDR == `DRT_ADDR_RL_HI)  ? reload_high_byte_reg :
        (I_SFR_ADDR == `DRT_ADDR_CNT_LO) ? count_low_byte_reg :
        (I_SFR_ADDR == `DRT_ADDR_CNT_HI) ? count_high_byte_reg :
                                           `DRT_RESET_BYTE;

    // mode from the written split bit
    wire drt_mode_t mode_wr = I_SFR_WDATA[`DRT_BIT_SPLIT] ?
                              DRT_MODE_SPLIT : DRT_MODE_WIDE;

    // ----------------------------------------------------------------
    // control bits written by software
    // ----------------------------------------------------------------
    // bit one has no storage, so writes to it vanish
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            low_byte_irq_enable_reg   <= 1'h0;
            lfo_capture_enable_reg    <= 1'h0;
            mode_reg                  <= DRT_MODE_WIDE;
            run_control_reg           <= 1'h0;
            external_clock_select_reg <= 1'h0;
        end else if (wr_ctrl) begin
            low_byte_irq_enable_reg   <= I_SFR_WDATA[`DRT_BIT_LOW_IEN];
            lfo_capture_enable_reg    <= I_SFR_WDATA[`DRT_BIT_CAP_EN];
            mode_reg                  <= mode_wr;
            run_control_reg           <= I_SFR_WDATA[`DRT_BIT_RUN];
            external_clock_select_reg <= I_SFR_WDATA[`DRT_BIT_XCLK];
        end
    end

    // ----------------------------------------------------------------
    // overflow flags
    // ----------------------------------------------------------------
    // never cleared by hardware, interrupt entry included
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            high_overflow_flag_reg <= 1'h0;
            low_overflow_flag_reg  <= 1'h0;
        end else begin
            high_overflow_flag_reg <= high_overflow_flag_next;
            low_overflow_flag_reg  <= low_overflow_flag_next;
        end
    end

    // ----------------------------------------------------------------
    // reload pair
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            reload_low_byte_reg  <= `DRT_RESET_BYTE;
            reload_high_byte_reg <= `DRT_RESET_BYTE;
        end else begin
            reload_low_byte_reg  <= reload_low_byte_next;
            reload_high_byte_reg <= reload_high_byte_next;
        end
    end

    // ----------------------------------------------------------------
    // count bytes
    // ----------------------------------------------------------------
    // a software write to a count byte beats its advance
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            count_low_byte_reg  <= `DRT_RESET_BYTE;
            count_high_byte_reg <= `DRT_RESET_BYTE;
        end else begin
            count_low_byte_reg  <= count_low_byte_next;
            count_high_byte_reg <= count_high_byte_next;
        end
    end

    // ----------------------------------------------------------------
    // read data, held until the next read
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) rdata_reg <= `DRT_RESET_BYTE;
        else if (I_SFR_RD) rdata_reg <= rd_mux;
    end

    // ----------------------------------------------------------------
    // interrupt request
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) irq_reg <= 1'h0;
        else irq_reg <= irq_next;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign O_SFR_RDATA = rdata_reg;
    assign O_IRQ_REQ   = irq_reg;
endmodule : drt_top

// ===== verif/drt_props.sv
// port checker of the dual mode reload timer
module drt_props (
    input wire logic       I_CLK,
    input wire logic       I_RST_N,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic       I_SFR_WR,
    input wire logic       I_SFR_RD,
    input wire logic       I_TIMER_IRQ_EN,
    input wire logic       I_HIGH_BYTE_CLOCK_SELECT,
    input wire logic       I_LOW_BYTE_CLOCK_SELECT,
    input wire logic       I_EXT_OSC,
    input wire logic       I_LFO,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic       O_IRQ_REQ
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    logic       rd_ctl_reg;
    logic [1:0] seen_reg;
    wire        rd_ctl = I_SFR_RD && I_SFR_ADDR == 8'h91;
    wire        wr_ctl = I_SFR_WR && I_SFR_ADDR == 8'h91;
    // flags read back as set, forgotten on a control write
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            rd_ctl_reg <= 1'b0;
            seen_reg   <= 2'h0;
        end else begin
            rd_ctl_reg <= rd_ctl && !I_SFR_WR;
            seen_reg   <= wr_ctl ? 2'h0 :
                          rd_ctl_reg ? O_SFR_RDATA[7:6] : seen_reg;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence wr_then_rd(a);
        (I_SFR_WR && I_SFR_ADDR == a) ##1 !I_SFR_WR
            ##1 (I_SFR_RD && I_SFR_ADDR == a);
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    rdata_hold_a: assert property (
        !I_SFR_RD |=> $stable(O_SFR_RDATA)) else $error("read data moved");
    unmapped_rd_a: assert property (
        I_SFR_RD && (I_SFR_ADDR < 8'h91 || I_SFR_ADDR > 8'h95)
        |=> O_SFR_RDATA == 8'h00) else $error("unmapped read not zero");
    ctrl_readback_a: assert property (
        wr_then_rd(8'h91) |=> O_SFR_RDATA[5:0] ==
        {$past(I_SFR_WDATA[5:2], 3), 1'b0, $past(I_SFR_WDATA[0], 3)})
        else $error("control readback wrong");
    reload_rd_a: assert property (
        wr_then_rd(8'h92) |=> O_SFR_RDATA == $past(I_SFR_WDATA, 3))
        else $error("reload readback wrong");
    count_hold_a: assert property (
        (wr_ctl && I_SFR_WDATA[3:2] == 2'h0) ##1 !I_SFR_WR
        ##1 wr_then_rd(8'h94) |=> O_SFR_RDATA == $past(I_SFR_WDATA, 3))
        else $error("stopped count moved");
    irq_gate_a: assert property (
        !I_TIMER_IRQ_EN |=> !O_IRQ_REQ) else $error("request while off");
    flags_sticky_a: assert property (
        rd_ctl |=> (O_SFR_RDATA[7:6] & seen_reg) == seen_reg)
        else $error("flag cleared by hardware");
    irq_flag_a: assert property (
        rd_ctl_reg && O_SFR_RDATA[7] && I_TIMER_IRQ_EN |=> O_IRQ_REQ)
        else $error("high flag without request");
endmodule // drt_props

bind drt_top drt_props chk_u (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SFR_ADDR(I_SFR_ADDR),
    .I_SFR_WDATA(I_SFR_WDATA), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD),
    .I_TIMER_IRQ_EN(I_TIMER_IRQ_EN),
    .I_HIGH_BYTE_CLOCK_SELECT(I_HIGH_BYTE_CLOCK_SELECT),
    .I_LOW_BYTE_CLOCK_SELECT(I_LOW_BYTE_CLOCK_SELECT),
    .I_EXT_OSC(I_EXT_OSC), .I_LFO(I_LFO), .O_SFR_RDATA(O_SFR_RDATA),
    .O_IRQ_REQ(O_IRQ_REQ)
);

// ===== verif/drt_osc_model.sv
// external oscillator and slow oscillator feeding the timer
module drt_osc_model #(
    parameter int HALF_NS = 13
) (
    input  wire logic i_ext_run,
    input  wire logic i_lfo_high,
    output logic      o_ext_osc,
    output logic      o_lfo
);
    timeunit 1ns;
    timeprecision 100ps;
    // unrelated to the system clock, parked low while off
    initial o_ext_osc = 1'b0;
    always #(HALF_NS) o_ext_osc = i_ext_run ? ~o_ext_osc : 1'b0;
    // slow source follows the requested level
    assign o_lfo = i_lfo_high;
endmodule // drt_osc_model

// ===== verif/drt_top_bench.sv
// self-checking bench of the dual mode reload timer
module drt_top_bench
    import drt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic      clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic      irq_en = 1'b0, sel_hi = 1'b0, sel_lo = 1'b1, ext_run = 1'b0;
    logic      lfo_hi = 1'b0, ext_osc, lfo, irq;
    drt_byte_t addr = 8'h00, wdata = 8'h00, rdata;
    int        error_cnt = 0, comparisons = 0;
    logic [3:0] cfg [4] = '{4'hc, 4'h9, 4'hb, 4'h4};
    drt_byte_t ex_lo [4] = '{8'h14, 8'h0b, 8'hf2, 8'h14};
    drt_byte_t ex_hi [4] = '{8'hf2, 8'h0b, 8'h0b, 8'h00};

    always #5 clk = ~clk;
    drt_top dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_SFR_ADDR(addr),
        .I_SFR_WDATA(wdata), .I_SFR_WR(wr_s), .I_SFR_RD(rd_s),
        .I_TIMER_IRQ_EN(irq_en), .I_HIGH_BYTE_CLOCK_SELECT(sel_hi),
        .I_LOW_BYTE_CLOCK_SELECT(sel_lo), .I_EXT_OSC(ext_osc), .I_LFO(lfo),
        .O_SFR_RDATA(rdata), .O_IRQ_REQ(irq));
    drt_osc_model osc_u (.i_ext_run(ext_run), .i_lfo_high(lfo_hi),
        .o_ext_osc(ext_osc), .o_lfo(lfo));
    // ----------------------------------------
    // register access and compare tasks
    // ----------------------------------------
    task automatic wr(input drt_byte_t a, input drt_byte_t d);
        addr  = a;
        wdata = d;
        wr_s  = 1'b1;
        @(posedge clk);
        #1 wr_s = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input drt_byte_t e,
                       input drt_byte_t v);
        comparisons++;
        if (v !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic rd(input drt_byte_t a, output drt_byte_t v);
        addr = a;
        rd_s = 1'b1;
        @(posedge clk);
        #1 rd_s = 1'b0;
        v = rdata;
        @(posedge clk);
        #1;
    endtask
    task automatic rc(input drt_byte_t a, input drt_byte_t e);
        drt_byte_t v;
        rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic ci(input logic e);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask
    // free-running sources: allow two ticks fewer or one more
    task automatic rr(input drt_byte_t a, input drt_byte_t e);
        drt_byte_t v;
        drt_byte_t d;
        rd(a, v);
        d = drt_byte_t'(v - e + 8'h02);
        comparisons++;
        if ((d <= 8'h03) !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED count %h expected %h seen %h", a, e, v);
        end
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        wr(8'h90, 8'hff);
        for (int i = 0; i < 7; i++) rc(8'h90 + i[7:0], 8'h00);
        wr(8'h91, 8'h3f);
        rc(8'h91, 8'h3d);
        wr(8'h91, 8'h00);
        wr(8'h94, 8'h5a);
        rc(8'h94, 8'h5a);
        #200;
        rc(8'h94, 8'h5a);
        // wide rollover loads the reload pair
        irq_en = 1'b1;
        wr(8'h92, 8'h34);
        rc(8'h92, 8'h34);
        wr(8'h93, 8'h12);
        wr(8'h94, 8'hff);
        wr(8'h95, 8'hff);
        wr(8'h91, 8'h04);
        rc(8'h91, 8'hc4);
        ci(1'b1);
        wr(8'h91, 8'hc0);
        rc(8'h91, 8'hc0);
        rc(8'h95, 8'h12);
        rc(8'h91, 8'hc0);
        ci(1'b1);
        wr(8'h91, 8'h00);
        ci(1'b0);
        // low byte request in both modes, enable on and off
        for (int m = 0; m < 4; m++) begin
            wr(8'h95, 8'h00);
            wr(8'h94, 8'hff);
            wr(8'h91, {2'h0, m[0], 1'h0, m[1], 3'h4});
            rc(8'h91, {2'h1, m[0], 1'h0, m[1], 3'h4});
            ci(m[0]);
            wr(8'h91, 8'h00);
        end
        // split: high held while stopped, then one tick
        wr(8'h92, 8'hf0);
        wr(8'h94, 8'hff);
        wr(8'h95, 8'hff);
        wr(8'h91, 8'h08);
        rc(8'h95, 8'hff);
        rc(8'h91, 8'h48);
        ci(1'b0);
        // run for one system clock tick; high flag written 0 still sets
        sel_hi = 1'b1;
        addr  = 8'h91;
        wdata = 8'h0c;
        wr_s  = 1'b1;
        @(posedge clk);
        #1 wdata = 8'h48;
        @(posedge clk);
        #1 wr_s = 1'b0;
        rc(8'h95, 8'h12);
        rc(8'h91, 8'hc8);
        ci(1'b1);
        wr(8'h91, 8'h00);
        // per-byte clock sources over a fixed window, split and wide
        for (int k = 0; k < 4; k++) begin
            wr(8'h94, 8'h00);
            wr(8'h95, 8'h00);
            {sel_hi, sel_lo} = cfg[k][2:1];
            ext_run = 1'b1;
            wr(8'h91, {4'h0, cfg[k][3], 2'h2, cfg[k][0]});
            #2400;
            wr(8'h91, 8'h00);
            rr(8'h94, ex_lo[k]);
            rr(8'h95, ex_hi[k]);
        end
        // slow source edge captures the held count
        wr(8'h94, 8'hcd);
        wr(8'h95, 8'hab);
        wr(8'h91, 8'h10);
        lfo_hi = 1'b1;
        #100;
        rc(8'h92, 8'hcd);
        rc(8'h93, 8'hab);
        rc(8'h91, 8'h90);
        ci(1'b1);
        final_report();
    end
endmodule // drt_top_bench
